// ---- hdl/slc_link_ctrl.sv ----
// deserializer link startup, sleep, interrupt relay and spread control
module slc_link_ctrl #(
   parameter int SLEEP_CYC = slc_pkg::SLEEP_CYC
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       eqDefaultPin,
   input  wire logic       spreadDefaultPin,
   input  wire logic       modeSelectPin,
   input  wire logic       hostSideSel,
   input  wire logic       rateRangePin,
   input  wire logic       irqInPin,
   input  wire logic       serialActivity,
   input  wire logic       serialLocked,
   input  wire logic       wakeupSeen,
   input  wire logic       cfgLinkActive,
   input  wire logic       serialTxEnable,
   input  wire logic       revChanReady,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       ackSent,
   output logic      [7:0] regRdData,
   output logic            irqTxValid,
   output logic            irqTxLevel,
   output logic      [3:0] eqBoost,
   output logic      [1:0] spreadSel,
   output logic            spreadOn,
   output logic            spreadWide,
   output logic      [5:0] sawtoothDivider,
   output logic            modTick,
   output logic            peripheralAddrSkip,
   output logic            sleepFlag,
   output logic            lowPower,
   output logic            pixelOutEnable,
   output logic            linkLockOut
);

   localparam int TW = $clog2(SLEEP_CYC + 1);
   localparam logic [TW-1:0] TIMER_END = TW'(SLEEP_CYC - 1);

   // ************************************************************
   // pin synchronisers and strap capture
   // ************************************************************
   logic [5:0] pinSync;
   logic       eqPin;
   logic       ssPin;
   logic       msPin;
   logic       hostPin;
   logic       rangePin;
   logic       irqLevel;

   slc_sync #(.WIDTH(6)) uPinSync (
      .clk     (clk),
      .arst_n  (arst_n),
      .async_i ({eqDefaultPin, spreadDefaultPin, modeSelectPin,
                 hostSideSel, rateRangePin, irqInPin}),
      .sync_o  (pinSync)
   );

   assign {eqPin, ssPin, msPin, hostPin, rangePin, irqLevel} = pinSync;

   logic [1:0] strapCnt_q;
   logic       strapDone_q;
   logic       hostSide_q;
   logic       strapLoad;

   // straps are valid once the synchroniser has filled
   assign strapLoad = !strapDone_q && (strapCnt_q == slc_pkg::STRAP_DELAY);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strapCnt_q  <= 2'h0;
         strapDone_q <= 1'b0;
         hostSide_q  <= 1'b0;
      end else begin
         if (!strapDone_q) begin
            strapCnt_q <= strapCnt_q + 2'h1;
         end
         if (strapLoad) begin
            strapDone_q <= 1'b1;
            hostSide_q  <= hostPin;
         end
      end
   end

   // ************************************************************
   // write staging until acknowledge
   // ************************************************************
   logic       pendValid_q;
   logic [7:0] pendAddr_q;
   logic [7:0] pendData_q;
   logic       applyWr;

   assign applyWr = pendValid_q && ackSent;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pendValid_q <= 1'b0;
         pendAddr_q  <= 8'h00;
         pendData_q  <= 8'h00;
      end else if (regWrEn) begin
         pendValid_q <= 1'b1;
         pendAddr_q  <= regAddr;
         pendData_q  <= regWrData;
      end else if (ackSent) begin
         pendValid_q <= 1'b0;
      end
   end

   logic wrDiv;
   logic wrEq;
   logic wrMisc;

   assign wrDiv  = applyWr && (pendAddr_q == slc_pkg::ADDR_SPREAD_DIV);
   assign wrEq   = applyWr && (pendAddr_q == slc_pkg::ADDR_EQ_BOOST);
   assign wrMisc = applyWr && (pendAddr_q == slc_pkg::ADDR_MISC);

   // ************************************************************
   // equalizer boost
   // ************************************************************
   logic [3:0] eqBoost_q;
   logic [3:0] eqWrCode;

   assign eqWrCode = pendData_q[slc_pkg::EQ_LSB +: slc_pkg::EQ_W];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         eqBoost_q <= slc_pkg::EQ_STRAP_LO;
      end else if (strapLoad) begin
         eqBoost_q <= eqPin ? slc_pkg::EQ_STRAP_HI
                            : slc_pkg::EQ_STRAP_LO;
      end else if (wrEq && eqWrCode <= slc_pkg::EQ_CODE_MAX) begin
         eqBoost_q <= eqWrCode;
      end
   end

   assign eqBoost = eqBoost_q;

   // ************************************************************
   // spread select and sawtooth divider
   // ************************************************************
   logic [1:0] spreadSel_q;
   logic [5:0] sawtooth_divider_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spreadSel_q <= slc_pkg::SS_STRAP_LO;
         sawtooth_divider_q      <= slc_pkg::SAWTOOTH_DIVIDER_RESET;
      end else if (strapLoad) begin
         spreadSel_q <= ssPin ? slc_pkg::SS_STRAP_HI
                              : slc_pkg::SS_STRAP_LO;
      end else if (wrDiv) begin
         // divider range is software's duty, not clamped here
         spreadSel_q <= pendData_q[slc_pkg::SPREAD_LSB +: 2];
         sawtooth_divider_q      <= pendData_q[slc_pkg::SAWTOOTH_DIVIDER_LSB +: slc_pkg::SAWTOOTH_DIVIDER_W];
      end
   end

   // spread touches only the parallel video clock, never audio
   assign spreadSel       = spreadSel_q;
   assign spreadOn        = slc_pkg::spread_on(spreadSel_q);
   assign spreadWide      = slc_pkg::spread_wide(spreadSel_q);
   assign sawtoothDivider = sawtooth_divider_q;

   logic [13:0] modLimit;
   logic [14:0] modAcc_q;
   logic [14:0] modNext;
   logic        modTick_q;

   assign modLimit = 14'(slc_pkg::MOD_COEFF * sawtooth_divider_q);
   // step is 1 + range pin, so the high range halves the period
   assign modNext  = modAcc_q + 15'h0001 + 15'(rangePin);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         modAcc_q  <= 15'h0000;
         modTick_q <= 1'b0;
      end else if (!spreadOn || sawtooth_divider_q == 6'h00) begin
         modAcc_q  <= 15'h0000;
         modTick_q <= 1'b0;
      end else if (modNext >= {1'b0, modLimit}) begin
         modAcc_q  <= 15'h0000;
         modTick_q <= 1'b1;
      end else begin
         modAcc_q  <= modNext;
         modTick_q <= 1'b0;
      end
   end

   assign modTick = modTick_q;

   // ************************************************************
   // addressing mode and interrupt relay
   // ************************************************************
   logic addrSkip_q;
   logic irqForce_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addrSkip_q <= 1'b0;
         irqForce_q <= 1'b0;
      end else begin
         if (wrEq) begin
            addrSkip_q <= pendData_q[slc_pkg::ADDR_SKIP_BIT];
         end
         if (wrMisc) begin
            irqForce_q <= pendData_q[slc_pkg::IRQ_FORCE_BIT];
         end
      end
   end

   assign peripheralAddrSkip = addrSkip_q;

   logic irqWant;
   logic irqSent_q;
   logic irqTxValid_q;

   assign irqWant = irqLevel || irqForce_q;

   // a mismatch stays pending while the channel is down
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irqSent_q    <= 1'b0;
         irqTxValid_q <= 1'b0;
      end else if (irqWant != irqSent_q && revChanReady) begin
         irqSent_q    <= irqWant;
         irqTxValid_q <= 1'b1;
      end else begin
         irqTxValid_q <= 1'b0;
      end
   end

   assign irqTxValid = irqTxValid_q;
   assign irqTxLevel = irqSent_q;

   // ************************************************************
   // startup and sleep sequencing
   // ************************************************************
   slc_pkg::slc_state_t state_q;
   slc_pkg::slc_state_t prevState_q;
   logic                sleepFlag_q;
   logic [TW-1:0]       timer_q;
   logic                timerDone;
   logic                sleepReq;
   logic                sleepCancel;

   // stale count from the last state must not end a fresh wait
   assign timerDone   = (timer_q >= TIMER_END) && (state_q == prevState_q);
   assign sleepReq    = wrEq && pendData_q[slc_pkg::SLEEP_BIT]
                        && !hostSide_q;
   assign sleepCancel = wrEq && !pendData_q[slc_pkg::SLEEP_BIT];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_q     <= '0;
         prevState_q <= slc_pkg::ST_SEARCH;
      end else begin
         prevState_q <= state_q;
         if (state_q != prevState_q) begin
            timer_q <= '0;
         end else if (!timerDone) begin
            timer_q <= timer_q + TW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q     <= slc_pkg::ST_SEARCH;
         sleepFlag_q <= 1'b0;
      end else if (strapLoad) begin
         if (!hostPin && msPin) begin
            state_q     <= slc_pkg::ST_ASLEEP;
            sleepFlag_q <= 1'b1;
         end else begin
            state_q     <= slc_pkg::ST_SEARCH;
            sleepFlag_q <= 1'b0;
         end
      end else begin
         unique case (state_q)
            slc_pkg::ST_SEARCH, slc_pkg::ST_LOCKED: begin
               // wake-up pulse is ignored while awake
               if (sleepReq) begin
                  state_q     <= slc_pkg::ST_SLEEP_WAIT;
                  sleepFlag_q <= 1'b1;
               end else if (state_q == slc_pkg::ST_SEARCH) begin
                  if (serialActivity && serialLocked) begin
                     state_q <= slc_pkg::ST_LOCKED;
                  end
               end else if (!serialLocked) begin
                  state_q <= slc_pkg::ST_SEARCH;
               end
            end
            slc_pkg::ST_SLEEP_WAIT: begin
               if (sleepCancel) begin
                  state_q     <= slc_pkg::ST_SEARCH;
                  sleepFlag_q <= 1'b0;
               end else if (!serialActivity || timerDone) begin
                  state_q <= slc_pkg::ST_ASLEEP;
               end
            end
            slc_pkg::ST_ASLEEP: begin
               if (wakeupSeen) begin
                  state_q <= slc_pkg::ST_WAKE;
               end
            end
            slc_pkg::ST_WAKE: begin
               if (serialLocked) begin
                  state_q     <= slc_pkg::ST_LOCKED;
                  sleepFlag_q <= 1'b0;
               end else if (timerDone) begin
                  state_q <= slc_pkg::ST_ASLEEP;
               end
            end
         endcase
      end
   end

   assign sleepFlag = sleepFlag_q;
   assign lowPower  = (state_q == slc_pkg::ST_ASLEEP);

   // ************************************************************
   // parallel output gating
   // ************************************************************
   logic cfgMode;

   // video link enable wins over the configuration link
   assign cfgMode = cfgLinkActive && !serialTxEnable;
   assign pixelOutEnable = (state_q == slc_pkg::ST_LOCKED)
                           && serialTxEnable && !cfgMode;
   assign linkLockOut    = pixelOutEnable;

   // ************************************************************
   // register readback
   // ************************************************************
   logic [7:0] rdData_q;
   logic [7:0] rdMux;

   always_comb begin
      rdMux = 8'h00;
      if (regAddr == slc_pkg::ADDR_SPREAD_DIV) begin
         rdMux = {spreadSel_q, sawtooth_divider_q};
      end else if (regAddr == slc_pkg::ADDR_EQ_BOOST) begin
         rdMux = {addrSkip_q, sleepFlag_q, 2'h0, eqBoost_q};
      end else if (regAddr == slc_pkg::ADDR_MISC) begin
         rdMux[slc_pkg::IRQ_STATE_BIT] = irqLevel;
         rdMux[slc_pkg::IRQ_FORCE_BIT] = irqForce_q;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_q <= 8'h00;
      end else if (regRdEn) begin
         rdData_q <= rdMux;
      end
   end

   assign regRdData = rdData_q;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_eq_strap_load: assert property (
      strapLoad |=> eqBoost == ($past(eqPin) ? 4'h4 : 4'h9))
      else $error("equalizer strap default wrong");

   a_ss_strap_load: assert property (
      strapLoad |=> spreadSel == ($past(ssPin) ? 2'h1 : 2'h0))
      else $error("spread strap default wrong");

   a_spread_decode: assert property (
      spreadOn == (spreadSel == 2'h1 || spreadSel == 2'h3))
      else $error("spread decode wrong");

   a_write_waits_ack: assert property (
      !applyWr && !strapLoad |=> $stable(eqBoost) && $stable(spreadSel))
      else $error("register changed before acknowledge");

   a_irq_relay_send: assert property (
      (irqWant != irqSent_q) && revChanReady
      |=> irqTxValid && irqTxLevel == $past(irqWant))
      else $error("interrupt transition not relayed");

   a_irq_held_down: assert property (
      !revChanReady |=> !irqTxValid)
      else $error("interrupt sent while channel down");

   a_irq_state_read: assert property (
      regRdEn && regAddr == 8'h06 |=> regRdData[4] == $past(irqLevel))
      else $error("interrupt level not readable");

   a_cfg_out_off: assert property (
      cfgMode |-> !pixelOutEnable && !linkLockOut)
      else $error("outputs on during config link");

   a_host_no_sleep: assert property (
      strapDone_q && hostSide_q |=> !sleepFlag && !lowPower)
      else $error("host-side device entered sleep");

   a_wake_timeout: assert property (
      state_q == slc_pkg::ST_WAKE && timerDone && !serialLocked
      |=> lowPower && sleepFlag)
      else $error("wake timeout not back to sleep");

   a_wake_lock: assert property (
      state_q == slc_pkg::ST_WAKE && serialLocked |=> !sleepFlag)
      else $error("sleep flag not cleared on lock");

   c_autostart_lock: cover property (
      state_q == slc_pkg::ST_SEARCH ##1 state_q == slc_pkg::ST_LOCKED);
   c_wake_lock: cover property (
      state_q == slc_pkg::ST_ASLEEP ##1 state_q == slc_pkg::ST_WAKE
      ##[1:50] state_q == slc_pkg::ST_LOCKED);
   c_irq_resend: cover property (
      !revChanReady && irqWant != irqSent_q ##[1:40] irqTxValid);
   c_mod_tick: cover property (modTick);

endmodule

// ---- hdl/slc_pkg.sv ----
// constants, types and helpers shared by the link startup control block
package slc_pkg;

   // ************************************************************
   // register offsets and fields
   // ************************************************************
   localparam logic [7:0] ADDR_SPREAD_DIV = 8'h03;
   localparam logic [7:0] ADDR_EQ_BOOST   = 8'h05;
   localparam logic [7:0] ADDR_MISC       = 8'h06;

   localparam int SAWTOOTH_DIVIDER_LSB       = 0;
   localparam int SAWTOOTH_DIVIDER_W         = 6;
   localparam int SPREAD_LSB     = 6;
   localparam int EQ_LSB         = 0;
   localparam int EQ_W           = 4;
   localparam int SLEEP_BIT      = 6;
   localparam int ADDR_SKIP_BIT  = 7;
   localparam int IRQ_STATE_BIT  = 4;
   localparam int IRQ_FORCE_BIT  = 5;

   // ************************************************************
   // reset and strap values
   // ************************************************************
   localparam logic [3:0] EQ_STRAP_HI   = 4'h4;
   localparam logic [3:0] EQ_STRAP_LO   = 4'h9;
   localparam logic [3:0] EQ_CODE_MAX   = 4'hb;
   localparam logic [1:0] SS_STRAP_HI   = 2'h1;
   localparam logic [1:0] SS_STRAP_LO   = 2'h0;
   localparam logic [1:0] SS_PCT2       = 2'h1;
   localparam logic [1:0] SS_PCT4       = 2'h3;
   localparam logic [5:0] SAWTOOTH_DIVIDER_RESET    = 6'h00;
   localparam logic [7:0] MOD_COEFF     = 8'hd0;
   localparam logic [5:0] SAWTOOTH_DIVIDER_MAX_PCT4 = 6'h0f;
   localparam logic [5:0] SAWTOOTH_DIVIDER_MAX_PCT2 = 6'h1e;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLEEP_TIME_MS = 8;
   localparam int SLEEP_CYC     =
      (SLEEP_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [1:0] STRAP_DELAY = 2'h2;

   typedef enum logic [2:0] {
      ST_SEARCH,
      ST_LOCKED,
      ST_SLEEP_WAIT,
      ST_ASLEEP,
      ST_WAKE
   } slc_state_t;

   // spread on for 01 and 11 only
   function automatic logic spread_on(input logic [1:0] sel);
      return sel[0];
   endfunction

   function automatic logic spread_wide(input logic [1:0] sel);
      return sel == SS_PCT4;
   endfunction

endpackage

// ---- hdl/slc_sync.sv ----
// two-flop synchroniser for pin inputs
module slc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule

// ---- tb/slc_ser_model.sv ----
// behavioural model of the paired serializer at the serial link
module slc_ser_model (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic linkOn,
   input  wire logic cfgOn,
   input  wire logic lockFail,
   output logic      serialActivity,
   output logic      serialLocked,
   output logic      wakeupSeen,
   output logic      serialTxEnable,
   output logic      cfgLinkActive,
   output logic      revChanReady
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] upCnt_q;

   // ********
   // startup
   // ********
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         upCnt_q <= 4'h0;
      end else if (!(linkOn | cfgOn)) begin
         upCnt_q <= 4'h0;
      end else if (upCnt_q != 4'hf) begin
         upCnt_q <= upCnt_q + 4'h1;
      end
   end

   // short wake pulse, sent once whatever the far state
   assign wakeupSeen     = upCnt_q == 4'h2;
   assign serialActivity = linkOn | cfgOn;
   // lockFail models a peer whose data never locks
   assign serialLocked   = upCnt_q > 4'h4 && !lockFail;
   // transmit enable follows the video link request alone
   assign serialTxEnable = linkOn;
   assign cfgLinkActive  = cfgOn && !linkOn;
   // reverse channel is late after each start
   assign revChanReady   = upCnt_q == 4'hf && !lockFail;
endmodule

// ---- tb/tb_slc_link_ctrl.sv ----
// self-checking bench for the link startup control block
module tb_slc_link_ctrl;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SCYC = 20;
   logic       clk = 1'b0, arst_n = 1'b0;
   logic       eqDefaultPin = 1'b0, spreadDefaultPin = 1'b0;
   logic       modeSelectPin = 1'b0, hostSideSel = 1'b0;
   logic       rateRangePin = 1'b0, irqInPin = 1'b0;
   logic       linkOn = 1'b0, cfgOn = 1'b0, lockFail = 1'b0;
   logic       regWrEn = 1'b0, regRdEn = 1'b0, ackSent = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
   logic [3:0] eqBoost, s, ex;
   logic [1:0] spreadSel;
   logic [5:0] sawtoothDivider, dv;
   logic [31:0] r;
   logic       serialActivity, serialLocked, wakeupSeen, serialTxEnable;
   logic       cfgLinkActive, revChanReady, irqTxValid, irqTxLevel;
   logic       spreadOn, spreadWide, modTick, peripheralAddrSkip;
   logic       sleepFlag, lowPower, pixelOutEnable, linkLockOut, sk, lv;
   int         seed, failures = 0, totalChecks = 0, sends = 0, g, c;

   always #5 clk = ~clk;

   slc_ser_model i_ser (.clk, .arst_n, .linkOn, .cfgOn, .lockFail,
      .serialActivity, .serialLocked, .wakeupSeen, .serialTxEnable,
      .cfgLinkActive, .revChanReady);

   slc_link_ctrl #(.SLEEP_CYC(SCYC)) i_dut (.clk, .arst_n, .eqDefaultPin,
      .spreadDefaultPin, .modeSelectPin, .hostSideSel, .rateRangePin,
      .irqInPin, .serialActivity, .serialLocked, .wakeupSeen,
      .cfgLinkActive, .serialTxEnable, .revChanReady, .regWrEn, .regRdEn,
      .regAddr, .regWrData, .ackSent, .regRdData, .irqTxValid,
      .irqTxLevel, .eqBoost, .spreadSel, .spreadOn, .spreadWide,
      .sawtoothDivider, .modTick, .peripheralAddrSkip, .sleepFlag,
      .lowPower, .pixelOutEnable, .linkLockOut);

   // counted off the edge so the pulse is never raced
   always @(negedge clk) begin
      if (irqTxValid === 1'b1) begin
         sends++;
      end
   end

   // ********
   // helpers
   // ********
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk(16'(got), 16'(exp));
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic int per(input int dvi, input int rr);
      return (208 * dvi + rr) / (1 + rr);
   endfunction

   task automatic boot(input logic [3:0] st);
      arst_n <= 1'b0;
      {hostSideSel, modeSelectPin, spreadDefaultPin, eqDefaultPin} <= st;
      cyc(10);
      arst_n <= 1'b1;
      cyc(6);
   endtask

   task automatic stage(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= v;
      @(posedge clk);
      regWrEn <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      stage(a, v);
      @(posedge clk);
      ackSent <= 1'b1;
      @(posedge clk);
      ackSent <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      cyc(1);
      v = regRdData;
   endtask

   task automatic expect_tx(input logic lvl);
      int n;
      n = 0;
      while (irqTxValid !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk1(irqTxValid, 1'b1);
      chk1(irqTxLevel, lvl);
      cyc(1);
   endtask

   task automatic tick_gap(output int gap);
      int n;
      n = 0;
      while (modTick !== 1'b1 && n < 4000) begin
         cyc(1);
         n++;
      end
      gap = 0;
      do begin
         cyc(1);
         gap++;
      end while (modTick !== 1'b1 && gap < 4000);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ********
   // sequence
   // ********
   initial begin
      seed = 32'hf827843f;
      for (int i = 0; i < 5; i++) begin
         r = $random(seed);
         s = (i == 4) ? 4'hf : {1'b0, r[0], 2'(i)};
         boot(s);
         chk(16'(eqBoost), s[0] ? 16'h4 : 16'h9);
         chk(16'(spreadSel), 16'(s[1]));
         chk1(sleepFlag, s[2] & !s[3]);
         chk1(lowPower, s[2] & !s[3]);
         if (s[3]) begin
            wr(8'h05, 8'h40);
            chk1(sleepFlag, 1'b0);
         end
      end
      r = $random(seed);
      rateRangePin <= r[0];
      boot(4'h0);
      ex = 4'h9;
      // every code, the illegal ones too
      for (int k = 0; k < 16; k++) begin
         r = $random(seed);
         sk = r[7];
         stage(8'h05, {sk, 3'h0, 4'(k)});
         chk(16'(eqBoost), 16'(ex));
         wr(8'h05, {sk, 3'h0, 4'(k)});
         ex = (k < 12) ? 4'(k) : ex;
         chk(16'(eqBoost), 16'(ex));
         chk1(peripheralAddrSkip, sk);
      end
      rd(8'h05, d);
      chk(16'(d), 16'({sk, 3'h0, ex}));
      rd(8'h07, d);
      chk(16'(d), 16'h0);
      for (int k = 0; k < 4; k++) begin
         dv = 6'(($random(seed) & 7) + 1);
         wr(8'h03, {2'(k), dv});
         chk1(spreadOn, k == 1 || k == 3);
         chk1(spreadWide, k == 3);
         chk(16'(sawtoothDivider), 16'(dv));
      end
      tick_gap(g);
      chk(16'(g), 16'(per(int'(dv), int'(rateRangePin))));
      linkOn <= 1'b1;
      cyc(25);
      chk1(linkLockOut, 1'b1);
      chk1(pixelOutEnable, 1'b1);
      lv = 1'b0;
      for (int k = 0; k < 5; k++) begin
         lv = ~lv;
         irqInPin <= lv;
         expect_tx(lv);
      end
      rd(8'h06, d);
      chk1(d[4], 1'b1);
      linkOn <= 1'b0;
      cyc(3);
      irqInPin <= 1'b0;
      c = sends;
      cyc(10);
      chk(16'(sends), 16'(c));
      linkOn <= 1'b1;
      expect_tx(1'b0);
      wr(8'h06, 8'h20);
      expect_tx(1'b1);
      wr(8'h06, 8'h00);
      expect_tx(1'b0);
      linkOn <= 1'b0;
      cfgOn <= 1'b1;
      cyc(25);
      chk1(pixelOutEnable, 1'b0);
      chk1(linkLockOut, 1'b0);
      linkOn <= 1'b1;
      cyc(25);
      chk1(linkLockOut, 1'b1);
      cfgOn <= 1'b0;
      // active link: only the timer can end the wait
      wr(8'h05, 8'h40);
      cyc(SCYC - 4);
      chk1(lowPower, 1'b0);
      cyc(8);
      chk1(lowPower, 1'b1);
      linkOn <= 1'b0;
      cyc(2);
      linkOn <= 1'b1;
      cyc(14);
      chk1(sleepFlag, 1'b0);
      chk1(lowPower, 1'b0);
      linkOn <= 1'b0;
      wr(8'h05, 8'h40);
      cyc(4);
      chk1(lowPower, 1'b1);
      lockFail <= 1'b1;
      linkOn <= 1'b1;
      cyc(8);
      chk1(lowPower, 1'b0);
      cyc(SCYC + 4);
      chk1(lowPower, 1'b1);
      chk1(sleepFlag, 1'b1);
      tally_and_finish();
   end

   // whole run is under 40 us
   initial begin
      #300000;
      failures++;
      tally_and_finish();
   end
endmodule
